// ==== dv/tb.sv ====
`timescale 1ns/1ps
// compare macro: counts every check, reports and counts each mismatch
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb import scc_pkg::*;;
    logic              mclk;           // 40 MHz system clock
    logic              sys_rst;        // sync reset, active high
    logic              clk_en;         // run enable
    logic              psel;           // apb select
    logic              penable;        // apb access phase
    logic              pwrite;         // apb direction
    logic [ADDR_W-1:0] paddr;          // apb byte address
    logic [DATA_W-1:0] pwdata;         // apb write data
    logic [DATA_W-1:0] prdata;         // apb read data
    logic              pready;         // apb answer
    logic              pslverr;        // apb error
    logic [TRIM_W-1:0] factory_trim;   // factory trim value
    logic              clock_output_fuse;
    logic [1:0]        startup_time_fuse;
    logic [3:0]        source_select_fuse;
    logic [3:0]        active_source;  // source now driving the unit
    logic [3:0]        reset_src;      // raw reset pins
    logic              trim_range_select;
    logic [6:0]        trim_fine_value;
    logic              sys_tick, cmd_valid, cmd_clock_out, internal_reset, io_reset;
    logic [2:0]        cmd_code;
    logic [3:0]        cmd_source;
    logic [1:0]        cmd_startup;
    logic [DATA_W-1:0] rd;             // last read data
    logic              er;             // last error flag
    int                err_count;
    int                total_checks;
    int                n;

    // short stretch counts keep the run brief
    scc_clock_ctrl #(.STRETCH_SHORT_CYC(20), .STRETCH_MID(40), .STRETCH_LONG(60)) u_dut (.*);

    // free-running clock, 25 ns period
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one apb transfer; an idle edge first so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        k = 0;
        do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin err_count++; tally_and_finish(); end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask

    // bounded wait for internal reset to reach a level; returns cycles waited
    task automatic wait_irst(input logic lvl);
        n = 0;
        do begin @(posedge mclk); n++; end while (internal_reset !== lvl && n < 300);
        if (n >= 300) begin err_count++; tally_and_finish(); end
    endtask

    // command through the register and check its pulse one cycle later
    task automatic cmd(input logic [2:0] c, input logic vld);
        apb(1, OFS_CMD, {29'h0, c});
        @(posedge mclk);
        `CHK(cmd_valid, vld)
    endtask

    initial begin
        err_count = 0; total_checks = 0;
        sys_rst = 1; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        factory_trim = 8'ha5; clock_output_fuse = 0; startup_time_fuse = 2'h1;
        source_select_fuse = 4'h2; active_source = 4'h2; reset_src = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 0;
        // fuses {0,01} pick the long stretch
        wait_irst(1'b0);
        `CHK(n > 50, 1'b1)
        apb(0, OFS_TRIM, 0);
        `CHK(rd[7:0], 8'ha5)
        `CHK({trim_range_select, trim_fine_value}, 8'ha5)
        apb(0, OFS_SEL, 0);
        `CHK(rd, 32'h0000_0052)
        apb(1, OFS_TRIM, 32'h0000_007f);
        @(posedge mclk);
        `CHK({trim_range_select, trim_fine_value}, 8'h7f)
        // top bit written one must still read zero
        apb(1, OFS_SEL, 32'h0000_00ff);
        apb(0, OFS_SEL, 0);
        `CHK(rd, 32'h0000_007f)
        active_source <= 4'h9;
        for (int c = 1; c <= 3; c++) begin
            cmd(c[2:0], 1'b1);
            `CHK({cmd_code, cmd_source, cmd_startup}, {c[2:0], 4'hf, 2'h3})
        end
        cmd(3'h5, 1'b1);
        `CHK(cmd_clock_out, 1'b1)
        cmd(3'h4, 1'b1);
        apb(0, OFS_SEL, 0);
        `CHK(rd, 32'h0000_0079)
        cmd(3'h6, 1'b0);
        apb(0, 8'h20, 0);
        `CHK({er, rd}, {1'b1, 32'h0})
        // divide by two, then an out-of-range write must be ignored
        apb(1, OFS_DIV, 32'h0000_0001);
        apb(1, OFS_DIV, 32'h0000_0009);
        apb(0, OFS_DIV, 0);
        `CHK(rd, 32'h0000_0001)
        apb(0, OFS_STATUS, 0);
        `CHK(rd, 32'h0000_0019)
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin @(posedge mclk); n++; end while (sys_tick !== 1'b1 && n < 20);
            `CHK(n <= 2, 1'b1)
        end
        n = 0;
        do begin @(posedge mclk); n++; end while (sys_tick !== 1'b1 && n < 20);
        `CHK(n, 2)
        // enable low right after a tick: the divider must stay frozen at no tick
        clk_en <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(sys_tick, 1'b0)
        @(posedge mclk);
        `CHK(sys_tick, 1'b0)
        clk_en <= 1'b1;
        // a reset pin sets the port reset at once, then the stretch reruns
        @(posedge mclk);
        reset_src <= 4'h1;
        #2;
        `CHK(io_reset, 1'b1)
        wait_irst(1'b1);
        `CHK(n <= 6, 1'b1)
        reset_src <= 4'h0;
        wait_irst(1'b0);
        `CHK(n > 50, 1'b1)
        repeat (3) @(posedge mclk);
        `CHK(io_reset, 1'b0)
        tally_and_finish();
    end
endmodule

// ==== inc/scc_pkg.sv ====
package scc_pkg;
    // apb map: byte addresses of aligned 32-bit words
    localparam int                ADDR_W     = 8;
    localparam int                DATA_W     = 32;
    localparam logic [ADDR_W-1:0] OFS_TRIM   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SEL    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DIV    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

    // oscillator trim layout
    localparam int TRIM_W         = 8;
    localparam int TRIM_RANGE_BIT = 7;
    localparam int TRIM_FINE_W    = 7;

    // clock selection layout
    localparam int SEL_RSVD_BIT   = 7;
    localparam int SEL_CLKOUT_BIT = 6;
    localparam int SEL_START_LO   = 4;
    localparam int START_W        = 2;
    localparam int SEL_SRC_LO     = 0;
    localparam int SRC_W          = 4;

    // divider: factor is two to the power of division_select
    localparam int                   DIV_SEL_W   = 4;
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_MAX = 4'h8;
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_RST = 4'h0;
    localparam int                   DIV_CNT_W   = 8;

    // status layout
    localparam int ST_SRC_LO     = 0;
    localparam int ST_DIV_LO     = 4;
    localparam int ST_SWITCH_BIT = 8;
    localparam int ST_IRST_BIT   = 9;

    // clock commands, written to the command register
    localparam int CMD_W = 3;
    typedef enum logic [CMD_W-1:0] {
        SCC_CMD_NONE, SCC_CMD_SRC_ENDIS, SCC_CMD_AVAIL, SCC_CMD_SWITCH, SCC_CMD_RECOVER, SCC_CMD_CLOCK_OUT
    } scc_cmd_t;

    // reset stretch timing
    localparam int RST_SRC_NUM      = 4;
    localparam int CLK_PERIOD_NS    = 25;
    localparam int STRETCH_BASE_CK  = 14;
    localparam int STRETCH_MID_US   = 4100;
    localparam int STRETCH_LONG_US  = 65000;
    localparam int STRETCH_MID_CYC  = STRETCH_BASE_CK + (STRETCH_MID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_LONG_CYC = STRETCH_BASE_CK + (STRETCH_LONG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRETCH_CNT_W    = 22;
    typedef enum logic [1:0] {SCC_DLY_SHORT, SCC_DLY_MID, SCC_DLY_LONG} scc_dly_t;
    // indexed by {source fuse bit 0, start-up fuse}
    localparam scc_dly_t STRETCH_KIND [8] = '{SCC_DLY_MID, SCC_DLY_LONG, SCC_DLY_SHORT, SCC_DLY_MID,
                                              SCC_DLY_LONG, SCC_DLY_SHORT, SCC_DLY_MID, SCC_DLY_LONG};
endpackage

// ==== logic/scc_clock_ctrl.sv ====
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module scc_clock_ctrl
    import scc_pkg::*;
#(
    parameter int NUM_SRC           = RST_SRC_NUM,
    parameter int STRETCH_SHORT_CYC = STRETCH_BASE_CK,
    parameter int STRETCH_MID       = STRETCH_MID_CYC,
    parameter int STRETCH_LONG      = STRETCH_LONG_CYC
)(
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic [DATA_W-1:0]       prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [TRIM_W-1:0]  factory_trim,
    input  wire logic               clock_output_fuse,
    input  wire logic [START_W-1:0] startup_time_fuse,
    input  wire logic [SRC_W-1:0]   source_select_fuse,
    input  wire logic [SRC_W-1:0]   active_source,
    input  wire logic [NUM_SRC-1:0] reset_src,
    output logic                    trim_range_select,
    output logic [TRIM_FINE_W-1:0]  trim_fine_value,
    output logic                    sys_tick,
    output logic                    cmd_valid,
    output logic [CMD_W-1:0]        cmd_code,
    output logic [SRC_W-1:0]        cmd_source,
    output logic [START_W-1:0]      cmd_startup,
    output logic                    cmd_clock_out,
    output logic                    internal_reset,
    output logic                    io_reset
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // register contents
    logic [TRIM_W-1:0]    oscillator_trim;   // live oscillator trim
    logic                 sel_clk_out;       // clock_output_bit
    logic [START_W-1:0]   sel_start;         // startup_time_field
    logic [SRC_W-1:0]     sel_src;           // source_select_field
    logic [DIV_SEL_W-1:0] division_select;   // last accepted division setting

    // fuse copies caught during reset
    logic [START_W-1:0]   fuse_start;
    logic                 fuse_src0;

    // bus decode
    logic                 setup;             // setup phase of a transfer
    logic                 wr_strobe;         // write takes effect this edge
    logic                 addr_hit;          // address maps a register
    logic                 wr_trim;
    logic                 wr_sel;
    logic                 wr_div;
    logic                 wr_cmd;
    logic                 div_ok;            // written division is legal
    logic                 cmd_ok;            // written command is known
    logic                 recover_wr;        // recover command taken this edge
    scc_cmd_t             cmd_in;            // command code on the bus
    logic [DATA_W-1:0]    next_prdata;

    // links to the sub-blocks
    logic [DIV_SEL_W-1:0]     active_div;
    logic                     div_switching;
    logic [STRETCH_CNT_W-1:0] stretch_target;

    assign setup     = psel & ~penable;
    assign wr_strobe = psel & penable & pready & pwrite & clk_en;
    assign addr_hit  = (paddr == OFS_TRIM) | (paddr == OFS_SEL) | (paddr == OFS_DIV) |
                       (paddr == OFS_CMD) | (paddr == OFS_STATUS);
    assign wr_trim   = wr_strobe & (paddr == OFS_TRIM);
    assign wr_sel    = wr_strobe & (paddr == OFS_SEL);
    assign wr_div    = wr_strobe & (paddr == OFS_DIV) & div_ok;
    assign wr_cmd    = wr_strobe & (paddr == OFS_CMD) & cmd_ok;
    assign div_ok    = (pwdata[DIV_SEL_W-1:0] <= DIV_SEL_MAX);
    assign cmd_in    = scc_cmd_t'(pwdata[CMD_W-1:0]);
    assign cmd_ok    = (cmd_in != SCC_CMD_NONE) && (cmd_in <= SCC_CMD_CLOCK_OUT);
    assign recover_wr = wr_cmd & (cmd_in == SCC_CMD_RECOVER);

    // trim halves drive the oscillator directly from the register
    assign trim_range_select = oscillator_trim[TRIM_RANGE_BIT];
    assign trim_fine_value   = oscillator_trim[TRIM_FINE_W-1:0];

    // apb answer: zero wait states, ready one cycle after setup
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup & ~addr_hit;
        end
    end

    // read mux, built from the setup-phase address
    always_comb begin
        next_prdata = '0;
        case (paddr)
            OFS_TRIM: begin
                next_prdata[TRIM_W-1:0] = oscillator_trim;
            end
            OFS_SEL: begin
                // top bit left at zero
                next_prdata[SEL_CLKOUT_BIT] = sel_clk_out;
                next_prdata[SEL_START_LO +: START_W] = sel_start;
                next_prdata[SEL_SRC_LO +: SRC_W] = sel_src;
            end
            OFS_DIV: begin
                next_prdata[DIV_SEL_W-1:0] = division_select;
            end
            OFS_CMD: begin
                next_prdata[CMD_W-1:0] = cmd_code;
            end
            OFS_STATUS: begin
                next_prdata[ST_SRC_LO +: SRC_W] = active_source;
                next_prdata[ST_DIV_LO +: DIV_SEL_W] = active_div;
                next_prdata[ST_SWITCH_BIT] = div_switching;
                next_prdata[ST_IRST_BIT] = internal_reset;
            end
            default: begin
                next_prdata = '0;
            end
        endcase
    end

    // read data is loaded at the setup edge and stands through the access
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (clk_en) begin
            if (setup && !pwrite) begin
                prdata <= next_prdata;
            end else begin
                prdata <= '0;
            end
        end
    end

    // oscillator trim: factory value while reset is held, then software
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            oscillator_trim <= factory_trim;
        end else if (clk_en && wr_trim) begin
            oscillator_trim <= pwdata[TRIM_W-1:0];
        end
    end

    // clock selection register; the recover command touches only the source
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sel_clk_out <= ~clock_output_fuse;
            sel_start   <= startup_time_fuse;
            sel_src     <= source_select_fuse;
        end else if (clk_en) begin
            if (wr_sel) begin
                sel_clk_out <= pwdata[SEL_CLKOUT_BIT];
                sel_start   <= pwdata[SEL_START_LO +: START_W];
                sel_src     <= pwdata[SEL_SRC_LO +: SRC_W];
            end else if (recover_wr) begin
                // clock-output bit and start-up field left alone
                sel_src <= active_source;
            end
        end
    end

    // fuse copies for the stretch length, caught while reset is held
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fuse_start <= startup_time_fuse;
            fuse_src0  <= source_select_fuse[0];
        end
    end

    // stretch length from the fuse table
    always_comb begin
        case (STRETCH_KIND[{fuse_src0, fuse_start}])
            SCC_DLY_MID: begin
                stretch_target = STRETCH_CNT_W'(STRETCH_MID);
            end
            SCC_DLY_LONG: begin
                stretch_target = STRETCH_CNT_W'(STRETCH_LONG);
            end
            default: begin
                stretch_target = STRETCH_CNT_W'(STRETCH_SHORT_CYC);
            end
        endcase
    end

    // division setting; out-of-range writes are dropped so the divider
    // never sees a factor it cannot count
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            division_select <= DIV_SEL_RST;
        end else if (clk_en && wr_div) begin
            division_select <= pwdata[DIV_SEL_W-1:0];
        end
    end

    // command issue: one-cycle pulse with the operands of the moment
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmd_valid     <= 1'h0;
            cmd_code      <= SCC_CMD_NONE;
            cmd_source    <= '0;
            cmd_startup   <= '0;
            cmd_clock_out <= 1'h0;
        end else if (clk_en) begin
            cmd_valid <= wr_cmd;
            if (wr_cmd) begin
                cmd_code      <= cmd_in;
                cmd_source    <= sel_src;
                cmd_startup   <= sel_start;
                cmd_clock_out <= sel_clk_out;
            end
        end
    end

    // glitch-free divider producing the system tick
    scc_prescaler #(
        .SEL_W (DIV_SEL_W),
        .CNT_W (DIV_CNT_W)
    ) u_prescaler (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .clk_en     (clk_en),
        .new_sel    (pwdata[DIV_SEL_W-1:0]),
        .new_sel_wr (wr_div),
        .tick       (sys_tick),
        .switching  (div_switching),
        .active_sel (active_div)
    );

    // reset stretch and immediate port reset
    scc_reset_stretch #(
        .NUM_SRC (NUM_SRC),
        .CNT_W   (STRETCH_CNT_W)
    ) u_reset_stretch (
        .mclk           (mclk),
        .sys_rst        (sys_rst),
        .clk_en         (clk_en),
        .reset_src      (reset_src),
        .target         (stretch_target),
        .internal_reset (internal_reset),
        .io_reset       (io_reset)
    );

    property p_trim_factory;
        $fell(sys_rst) |-> oscillator_trim == $past(factory_trim);
    endproperty
    a_trim_factory: assert property (p_trim_factory) else $error("trim not loaded at reset");

    property p_sel_rsvd_zero;
        (setup && !pwrite && paddr == OFS_SEL && clk_en) |=> (pready && !prdata[SEL_RSVD_BIT]);
    endproperty
    a_sel_rsvd_zero: assert property (p_sel_rsvd_zero) else $error("reserved bit read as one");

    property p_clkout_init;
        $fell(sys_rst) |-> sel_clk_out == !$past(clock_output_fuse);
    endproperty
    a_clkout_init: assert property (p_clkout_init) else $error("clock-output bit not inverted fuse");

    property p_recover_clkout;
        recover_wr |=> $stable(sel_clk_out);
    endproperty
    a_recover_clkout: assert property (p_recover_clkout) else $error("recover changed clock-output");

    property p_start_init;
        $fell(sys_rst) |-> sel_start == $past(startup_time_fuse);
    endproperty
    a_start_init: assert property (p_start_init) else $error("start-up field not from fuse");

    property p_recover_start;
        recover_wr |=> sel_start == $past(sel_start);
    endproperty
    a_recover_start: assert property (p_recover_start) else $error("recover changed start-up");

    property p_src_init;
        $fell(sys_rst) |-> sel_src == $past(source_select_fuse);
    endproperty
    a_src_init: assert property (p_src_init) else $error("source field not from fuse");

    property p_cmd_operands;
        (cmd_valid && $past(clk_en)) |-> (cmd_source == $past(sel_src)) && (cmd_startup == $past(sel_start));
    endproperty
    a_cmd_operands: assert property (p_cmd_operands) else $error("command operands wrong");

    property p_recover_src;
        recover_wr |=> ##1 sel_src == $past(active_source, 2);
    endproperty
    a_recover_src: assert property (p_recover_src) else $error("recover source not loaded");

    c_recover:  cover property (recover_wr);
    c_div_wr:   cover property (wr_div ##[1:600] !div_switching);
    c_release:  cover property ($fell(internal_reset));
    c_unmapped: cover property (pslverr);
endmodule

// ==== logic/scc_prescaler.sv ====
`timescale 1ns/1ps
module scc_prescaler
    import scc_pkg::*;
#(
    parameter int SEL_W = DIV_SEL_W,
    parameter int CNT_W = DIV_CNT_W
)(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic [SEL_W-1:0] new_sel,
    input  wire logic             new_sel_wr,
    output logic                  tick,
    output logic                  switching,
    output logic [SEL_W-1:0]      active_sel
);
    localparam int SW_BOUND = 520;   // worst old period plus new period plus margin
    logic [CNT_W-1:0] ripple;        // free count at the undivided clock
    logic [CNT_W-1:0] last_val;      // terminal count of the setting in force
    logic [SEL_W-1:0] pend_sel;      // setting waiting for the old period to end
    logic             pend;
    logic             arm;           // first new edge produced, awaiting second
    logic [CNT_W:0]   gap;           // helper: cycles since the previous tick

    assign last_val  = CNT_W'((1 << active_sel) - 1);
    assign switching = pend | arm;

    // divider runs from mclk itself, so it serves every source choice
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ripple <= '0;
            tick   <= 1'h0;
        end else if (clk_en) begin
            tick <= (ripple == last_val);
            if (ripple == last_val) begin
                ripple <= '0;
            end else begin
                ripple <= ripple + 1'h1;
            end
        end
    end

    // a new setting only takes over at the end of a whole old period,
    // so no shortened period, hence no faster intermediate rate
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            active_sel <= DIV_SEL_RST;
            pend_sel   <= DIV_SEL_RST;
            pend       <= 1'h0;
            arm        <= 1'h0;
        end else if (clk_en) begin
            if (new_sel_wr) begin
                pend     <= 1'h1;
                pend_sel <= new_sel;
            end else if (ripple == last_val && pend) begin
                active_sel <= pend_sel;
                pend       <= 1'h0;
                arm        <= 1'h1;
            end else if (ripple == last_val && arm) begin
                arm <= 1'h0;
            end
        end
    end

    // helper count for the period checks
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gap <= '0;
        end else if (clk_en) begin
            gap <= tick ? (CNT_W+1)'(1) : gap + 1'h1;
        end
    end

    property p_period_whole;
        @(posedge mclk) disable iff (sys_rst)
        (tick && gap != '0) |-> gap == (CNT_W+1)'(1 << $past(active_sel));
    endproperty
    a_period_whole: assert property (p_period_whole) else $error("divided period cut short");

    property p_switch_bounded;
        @(posedge mclk) disable iff (sys_rst)
        $rose(pend) |-> ##[1:SW_BOUND] !switching;
    endproperty
    a_switch_bounded: assert property (p_switch_bounded) else $error("division change too slow");
endmodule

// ==== logic/scc_reset_stretch.sv ====
`timescale 1ns/1ps
module scc_reset_stretch
    import scc_pkg::*;
#(
    parameter int NUM_SRC = RST_SRC_NUM,
    parameter int CNT_W   = STRETCH_CNT_W
)(
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               clk_en,
    input  wire logic [NUM_SRC-1:0] reset_src,
    input  wire logic [CNT_W-1:0]   target,
    output logic                    internal_reset,
    output logic                    io_reset
);
    logic [NUM_SRC-1:0] filt;     // settled reset source levels
    logic [CNT_W-1:0]   cnt;      // cycles since all sources went quiet
    logic               any_src;
    logic               raw_any;
    logic [NUM_SRC-1:0] busy;     // a caught level still in some catch stage

    // three-stage catch per pin; a level counts once stages two and three agree
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        logic s1, s2, s3, f;
        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                {s1, s2, s3, f} <= 4'h0;
            end else if (clk_en) begin
                s1 <= reset_src[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    f <= s3;
                end
            end
        end
        assign filt[i] = f;
        assign busy[i] = s1 | s2 | s3 | f;
    end

    assign any_src = |filt;
    assign raw_any = |reset_src;

    // stretch the internal reset until the fuse-chosen count has run out
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt            <= '0;
            internal_reset <= 1'h1;
        end else if (clk_en) begin
            if (any_src) begin
                cnt            <= '0;
                internal_reset <= 1'h1;
            end else if (cnt < target) begin
                cnt <= cnt + 1'h1;
            end else begin
                internal_reset <= 1'h0;
            end
        end
    end

    // ports go to their idle state straight from the pin, no clock needed;
    // a glitch on a pin can also set it, which is the safe direction
    always_ff @(posedge mclk or posedge raw_any) begin
        if (raw_any) begin
            io_reset <= 1'h1;
        end else if (sys_rst) begin
            io_reset <= 1'h1;
        end else if (clk_en && !internal_reset && !(|busy)) begin
            // a short pulse still in the catch stages keeps ports held,
            // otherwise they would drop and be grabbed again a few edges later
            io_reset <= 1'h0;
        end
    end

    property p_stretch_full;
        @(posedge mclk) disable iff (sys_rst)
        $fell(internal_reset) |-> $past(cnt) == target;
    endproperty
    a_stretch_full: assert property (p_stretch_full) else $error("internal reset released early");

    property p_ports_held;
        @(posedge mclk) disable iff (sys_rst)
        any_src |-> io_reset;
    endproperty
    a_ports_held: assert property (p_ports_held) else $error("ports released during reset");
endmodule
